/* hw/irq_en_pkg.sv */
/*
 * constants and carriers for the interrupt-enable block
 * assumes: included before the design module
 */
package irq_en_pkg;
   localparam int          WORD_BITS      = 16;
   localparam int          ADDR_HI        = 15;
   localparam int          ADDR_LO        = 14;
   localparam logic [1:0]  ADDR_IRQ_EN    = 2'h1;
   localparam int          RDSEL_BIT      = 13;
   localparam int          NOWR_BIT       = 12;
   localparam int          NSRC           = 12;
   localparam int          B_OVF          = 11;
   localparam int          B_THERM        = 10;
   localparam int          B_GND          = 9;
   localparam int          B_SPICNT       = 8;
   localparam int          B_BAT          = 7;
   localparam int          B_REG          = 6;
   localparam int          B_HSF          = 5;
   localparam int          B_SBF          = 4;
   localparam int          B_LOCAL        = 3;
   localparam int          B_DOGRS        = 2;
   localparam int          B_HSW          = 1;
   localparam int          B_SBW          = 0;
   localparam logic [11:0] EN_RESET       = 12'h000;
   localparam logic [11:0] CAUSE_RESET    = 12'h000;
   localparam logic [4:0]  CNT_GOOD       = 5'h10;
   localparam logic [1:0]  XCVR_ACTIVE    = 2'h3;
   localparam logic [1:0]  XCVR_ONLINE    = 2'h2;
   localparam logic [1:0]  XCVR_LISTEN    = 2'h1;
   localparam logic [1:0]  XCVR_OFFLINE   = 2'h0;

   typedef enum logic [2:0] {
      MODE_STARTUP, MODE_RESTART, MODE_STANDBY, MODE_NORMAL, MODE_FLASH,
      MODE_OTHER
   } sys_mode_e;

   // raw event inputs from the rest of the chip
   typedef struct packed {
      logic       wdog_overflow;
      logic       wdog_restart_off;
      logic       temp_warn;
      logic       gnd_shift;
      logic       sense_in;
      logic       core_supply_ok;
      logic       transceiver_supply_ok;
      logic       aux_supply_ok;
      logic [3:0] hs_fail_code;
      logic [1:0] sb_fail_code;
      logic       hs_wake;
      logic       sb_wake;
      logic       hs_active;
      logic       sb_active;
   } evt_s;
endpackage

/* hw/irq_en_logic.sv */
/*
 * interrupt-enable logic: spi command decode, enable register, cause
 * register, reset requests and transceiver state reporting
 * assumes: spi pins and the wake pin are asynchronous to mclk; event
 * inputs in evt come from logic already on mclk
 */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - command top bits 01 address enable register
// - bit 13 picks cause or enable readback
// - bit 12 set suppresses enable write
// - overflow enable: interrupt, else reset in standby
// - overflow event clears its enable bit
// - temperature warning change raises interrupt if enabled
// - ground shift change raises interrupt if enabled
// - bad clock count: interrupt, reset in startup/restart
// - bad clock count access is discarded
// - sense falling edge raises interrupt if enabled
// - supply diagnosis falling raises interrupt if enabled
// - bus fault code change raises interrupt
// - sub-bus fault code change raises interrupt
// - wake falling edge interrupt in normal/flash/standby
// - wake disabled: reset in standby only
// - watchdog restart while off raises interrupt
// - bus wake interrupt in standby, in normal/flash unless transceiver active
// - bus wake disabled: reset in standby
// - sub-bus wake interrupt in standby, in normal/flash unless active
// - sub-bus wake disabled: reset in standby
// - low diagnosis bits report transceiver state
// - supply diagnosis set again on reactivation
// - cause clears on read, new events kept
// - wake input needs global enable
module irq_en_logic
   import irq_en_pkg::*;
#(
   parameter int W = WORD_BITS
) (
   input  wire logic         mclk,
   input  wire logic         nrst,
   input  wire logic         spi_sck,
   input  wire logic         spi_cs_n,
   input  wire logic         spi_mosi,
   output logic              spi_miso,
   input  wire logic         wake_pin,
   input  wire logic         wake_global_en,
   input  wire logic         transceiver_supply_on,
   input  wire sys_mode_e    mode,
   input  wire evt_s         evt,
   output logic              irq_out_low,
   output logic              reset_req,
   output logic [1:0]        transceiver_state_code,
   output logic              transceiver_supply_ok,
   output logic [NSRC-1:0]   irq_enable_readback
);

   ////////////////////////////////////////////////////////////////////////
   // synchronisers for pins: first stage read only by the second
   logic [2:0] s1_r, s2_r, s3_r;
   logic [2:0] s1_nxt, s2_nxt, s3_nxt;
   always_comb begin
      s1_nxt = {spi_sck, spi_cs_n, wake_pin};
      s2_nxt = s1_r;
      s3_nxt = s2_r;
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         // sck parks low, select and wake idle high: no false edges
         s1_r <= 3'h3;
         s2_r <= 3'h3;
         s3_r <= 3'h3;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
      end
   end
   logic sck_rise, sck_fall, cs_fall, cs_rise, wake_fall, cs_n_s;
   assign sck_rise  = s2_r[2] & ~s3_r[2];
   assign sck_fall  = ~s2_r[2] & s3_r[2];
   assign cs_fall   = ~s2_r[1] & s3_r[1];
   assign cs_rise   = s2_r[1] & ~s3_r[1];
   assign cs_n_s    = s2_r[1];
   assign wake_fall = ~s2_r[0] & s3_r[0];

   // mosi sampled through two flops as well; sck is slow enough
   logic mosi1_r, mosi2_r;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mosi1_r <= 1'b0;
         mosi2_r <= 1'b0;
      end else begin
         mosi1_r <= spi_mosi;
         mosi2_r <= mosi1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // spi shift path and command execution
   logic [W-1:0]    sh_r, sh_nxt, tx_r, tx_nxt;
   logic [4:0]      cnt_r, cnt_nxt;
   logic [NSRC-1:0] en_r, en_nxt, cause_r, cause_nxt;
   logic            miso_r, miso_nxt;
   logic            good_frame, addr_hit, cause_read, bad_count;
   logic [NSRC-1:0] ev;
   logic            ovf_reset, local_reset, hs_reset, sb_reset, cnt_reset;

   assign good_frame = cs_rise && (cnt_r == CNT_GOOD);
   assign bad_count  = cs_rise && (cnt_r != CNT_GOOD);
   assign addr_hit   = good_frame &&
                       (sh_r[ADDR_HI:ADDR_LO] == ADDR_IRQ_EN);
   // cause is cleared by the read that happened in this frame
   assign cause_read = addr_hit && sh_r[RDSEL_BIT];

   // readback image: the enable view is loaded at frame start; once the
   // third bit marks a cause read of this register, the data field is
   // swapped for the cause image before its first bit leaves. shown_r
   // keeps the bits that went out, so a read clears only what the host
   // saw and an event arriving mid-frame survives
   logic [NSRC-1:0] shown_r, shown_nxt;
   logic [2:0]      head;
   always_comb begin
      sh_nxt    = sh_r;
      tx_nxt    = tx_r;
      cnt_nxt   = cnt_r;
      miso_nxt  = miso_r;
      shown_nxt = shown_r;
      head      = {sh_r[1:0], mosi2_r};
      if (cs_fall) begin
         cnt_nxt   = 5'h00;
         shown_nxt = '0;
         tx_nxt    = {ADDR_IRQ_EN, 2'h0, en_r};
         miso_nxt  = tx_nxt[W-1];
      end else if (!cs_n_s && sck_rise) begin
         sh_nxt  = {sh_r[W-2:0], mosi2_r};
         if (cnt_r != 5'h1f)
            cnt_nxt = cnt_r + 5'h01;
         // two bits already shifted out, so the field sits at 13:2
         if (cnt_r == 5'h02 && head == {ADDR_IRQ_EN, 1'b1}) begin
            tx_nxt[NSRC+1:2] = cause_r;
            shown_nxt        = cause_r;
         end
      end else if (!cs_n_s && sck_fall) begin
         tx_nxt   = {tx_r[W-2:0], 1'b0};
         miso_nxt = tx_nxt[W-1];
      end
      // a bit set again after it was sent is not cleared by this read
      shown_nxt = shown_nxt & ~ev;
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sh_r    <= '0;
         tx_r    <= '0;
         cnt_r   <= 5'h00;
         miso_r  <= 1'b0;
         shown_r <= '0;
      end else begin
         sh_r    <= sh_nxt;
         tx_r    <= tx_nxt;
         cnt_r   <= cnt_nxt;
         miso_r  <= miso_nxt;
         shown_r <= shown_nxt;
      end
   end
   assign spi_miso = miso_r;

   ////////////////////////////////////////////////////////////////////////
   // previous values for change detection
   logic       tw_r, gs_r, sense_r, ovf_r, rst_r;
   logic [2:0] sup_r;
   logic [3:0] hsf_r;
   logic [1:0] sbf_r;
   logic       hsw_r, sbw_r, dr_r;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tw_r  <= 1'b0;
         gs_r  <= 1'b0;
         sense_r <= 1'b1;
         sup_r <= 3'h7;
         hsf_r <= 4'h0;
         sbf_r <= 2'h0;
         ovf_r <= 1'b0;
         hsw_r <= 1'b0;
         sbw_r <= 1'b0;
         dr_r  <= 1'b0;
      end else begin
         tw_r  <= evt.temp_warn;
         gs_r  <= evt.gnd_shift;
         sense_r <= evt.sense_in;
         sup_r <= {evt.core_supply_ok, evt.transceiver_supply_ok,
                   evt.aux_supply_ok};
         hsf_r <= evt.hs_fail_code;
         sbf_r <= evt.sb_fail_code;
         ovf_r <= evt.wdog_overflow;
         hsw_r <= evt.hs_wake;
         sbw_r <= evt.sb_wake;
         dr_r  <= evt.wdog_restart_off;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // event detection and reset requests
   logic wake_ok, in_std, in_nfs, in_boot, ovf_ev, hsw_ev, sbw_ev, lw_ev;
   assign in_std  = (mode == MODE_STANDBY);
   assign in_nfs  = in_std || mode == MODE_NORMAL || mode == MODE_FLASH;
   assign in_boot = (mode == MODE_STARTUP) || (mode == MODE_RESTART);
   assign wake_ok = wake_global_en;
   assign ovf_ev  = evt.wdog_overflow & ~ovf_r;
   assign hsw_ev  = evt.hs_wake & ~hsw_r;
   assign sbw_ev  = evt.sb_wake & ~sbw_r;
   assign lw_ev   = wake_fall & wake_ok;
   always_comb begin
      ev = '0;
      ev[B_OVF]    = ovf_ev & in_std & en_r[B_OVF];
      ev[B_THERM]  = (evt.temp_warn ^ tw_r) & en_r[B_THERM];
      ev[B_GND]    = (evt.gnd_shift ^ gs_r) & en_r[B_GND];
      ev[B_SPICNT] = bad_count & en_r[B_SPICNT] & ~in_boot;
      ev[B_BAT]    = ~evt.sense_in & sense_r & en_r[B_BAT];
      ev[B_REG]    = (|(sup_r & ~{evt.core_supply_ok,
                       evt.transceiver_supply_ok, evt.aux_supply_ok}))
                     & en_r[B_REG];
      ev[B_HSF]    = (evt.hs_fail_code != hsf_r) & en_r[B_HSF];
      ev[B_SBF]    = (evt.sb_fail_code != sbf_r) & en_r[B_SBF];
      ev[B_LOCAL]  = lw_ev & in_nfs & en_r[B_LOCAL];
      ev[B_DOGRS]  = evt.wdog_restart_off & ~dr_r & en_r[B_DOGRS];
      ev[B_HSW]    = hsw_ev & en_r[B_HSW] &
                     (in_std | (in_nfs & ~evt.hs_active));
      ev[B_SBW]    = sbw_ev & en_r[B_SBW] &
                     (in_std | (in_nfs & ~evt.sb_active));
   end
   assign ovf_reset   = ovf_ev & in_std & ~en_r[B_OVF];
   assign cnt_reset   = bad_count & en_r[B_SPICNT] & in_boot;
   assign local_reset = lw_ev & in_std & ~en_r[B_LOCAL];
   assign hs_reset    = hsw_ev & in_std & ~en_r[B_HSW];
   assign sb_reset    = sbw_ev & in_std & ~en_r[B_SBW];

   ////////////////////////////////////////////////////////////////////////
   // enable and cause registers; a set always beats the read clear
   logic rst_nxt;
   always_comb begin
      en_nxt = en_r;
      if (addr_hit && !sh_r[NOWR_BIT])
         en_nxt = sh_r[NSRC-1:0];
      if (ovf_ev)
         en_nxt[B_OVF] = 1'b0;
      cause_nxt = (cause_read ? cause_r & ~shown_r : cause_r) | ev;
      rst_nxt   = ovf_reset | cnt_reset | local_reset |
                  hs_reset | sb_reset;
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         en_r    <= EN_RESET;
         cause_r <= CAUSE_RESET;
         rst_r   <= 1'b0;
      end else begin
         en_r    <= en_nxt;
         cause_r <= cause_nxt;
         rst_r   <= rst_nxt;
      end
   end
   assign irq_out_low         = ~(|cause_r);
   assign reset_req           = rst_r;
   assign irq_enable_readback = en_r;

   // transceiver state and supply diagnosis reporting
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         transceiver_state_code <= XCVR_OFFLINE;
         transceiver_supply_ok  <= 1'b1;
      end else begin
         transceiver_state_code <= !transceiver_supply_on ? XCVR_OFFLINE :
            evt.hs_active ? XCVR_ACTIVE : XCVR_ONLINE;
         if (!evt.transceiver_supply_ok)
            transceiver_supply_ok <= 1'b0;
         else if (transceiver_supply_on)
            transceiver_supply_ok <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   a_ovf_clear: assert property (@(posedge mclk) disable iff (!nrst)
      ovf_ev |=> !en_r[B_OVF]) else $error("overflow enable kept");
   a_bad_nowrite: assert property (@(posedge mclk) disable iff (!nrst)
      bad_count && !ovf_ev |=> en_r == $past(en_r))
      else $error("bad frame wrote");
   a_ro_keep: assert property (@(posedge mclk) disable iff (!nrst)
      addr_hit && sh_r[NOWR_BIT] && !ovf_ev |=> $stable(en_r))
      else $error("read only wrote");
   a_write_load: assert property (@(posedge mclk) disable iff (!nrst)
      addr_hit && !sh_r[NOWR_BIT] && !ovf_ev |=>
      en_r == $past(sh_r[NSRC-1:0])) else $error("enable not loaded");
   a_event_kept: assert property (@(posedge mclk) disable iff (!nrst)
      |ev |=> |cause_r) else $error("event lost");
   a_ovf_reset: assert property (@(posedge mclk) disable iff (!nrst)
      ovf_reset |=> reset_req) else $error("no overflow reset");
   a_local_gate: assert property (@(posedge mclk) disable iff (!nrst)
      !wake_global_en |-> !ev[B_LOCAL] && !local_reset)
      else $error("wake ungated");
   a_irq_pin: assert property (@(posedge mclk) disable iff (!nrst)
      ev[B_THERM] |=> !irq_out_low) else $error("irq not raised");
   a_read_clear: assert property (@(posedge mclk) disable iff (!nrst)
      cause_read |=>
      (cause_r & $past(shown_r)) == ($past(ev) & $past(shown_r)))
      else $error("cause not cleared");
endmodule
`default_nettype wire

/* sim/spi_host_model.sv */
/* host microcontroller model, spi master in mode 0, msb first
   assumes: sck half period 62.5 ns, far above four device clocks */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   output logic        spi_sck,
   output logic        spi_cs_n,
   output logic        spi_mosi,
   input  wire logic   spi_miso,
   output logic [15:0] rx_word,
   output logic        rx_done
);
   // idle: select high, clock parked low between frames
   initial begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
      rx_word = 16'h0000;
      rx_done = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////
   // one frame of n clocks; n other than 16 is a deliberate count fault
   task automatic frame(input logic [15:0] w, input int n);
      logic [15:0] r;
      r = 16'h0000;
      spi_cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         spi_mosi = w[15 - (i % 16)];
         #62.5 spi_sck = 1'b1;
         r = {r[14:0], spi_miso};
         #62.5 spi_sck = 1'b0;
      end
      #62.5 spi_cs_n = 1'b1;
      // released data line must not keep showing the last bit
      spi_mosi = ~spi_mosi;
      rx_word = r;
      rx_done = 1'b1;
      #8 rx_done = 1'b0;
      // idle gap well past the four-clock minimum
      #500;
   endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
/* self-checking bench for the interrupt-enable block
   assumes: package and host model compiled first */
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import irq_en_pkg::*;
;
   logic        mclk, nrst, wake_global_en, transceiver_supply_on;
   logic [18:0] ins;
   sys_mode_e   mode;
   wire         sck, cs_n, mosi, miso, irq_out_low, reset_req, rx_done;
   wire         sup_ok;
   wire [1:0]   code;
   wire [11:0]  en_rb;
   wire [15:0]  rx_word;
   wire [15:0]  irq_w = {15'h0000, irq_out_low};
   wire [15:0]  en_w = {4'h0, en_rb};
   int          mismatches = 0;
   int          checks_done = 0;
   int          resets = 0;
   int          cycles = 0;
   logic [16:0] exp_q[$];
   logic [16:0] note;
   logic [31:0] seed = 32'h0000b8df;
   logic [18:0] ev_m [11] = '{19'h40000, 19'h10000, 19'h08000, 19'h04000,
      19'h02000, 19'h01000, 19'h00400, 19'h00040, 19'h00010, 19'h00008,
      19'h00004};
   int          ev_b [11] = '{B_LOCAL, B_DOGRS, B_THERM, B_GND, B_BAT, B_REG,
      B_REG, B_HSF, B_SBF, B_HSW, B_SBW};
   logic [18:0] rs_m [4] = '{19'h40000, 19'h20000, 19'h00008, 19'h00004};

   irq_en_logic DUT (.mclk(mclk), .nrst(nrst), .spi_sck(sck),
      .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
      .wake_pin(ins[18]), .wake_global_en(wake_global_en),
      .transceiver_supply_on(transceiver_supply_on), .mode(mode),
      .evt(evt_s'(ins[17:0])), .irq_out_low(irq_out_low),
      .reset_req(reset_req), .transceiver_state_code(code),
      .transceiver_supply_ok(sup_ok), .irq_enable_readback(en_rb));
   spi_host_model host (.spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi),
      .spi_miso(miso), .rx_word(rx_word), .rx_done(rx_done));
   ////////////////////////////////////////////////////////////////////
   // clock, hang guard and reset pulse counter
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (reset_req === 1'b1) resets++;
      if (cycles == 40000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   // watcher: each finished frame pops the oldest note, compared only when its flag bit is set
   always @(posedge rx_done) begin
      note = exp_q.pop_front();
      if (note[16]) check(rx_word, note[15:0]);
   end
   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      checks_done++;
      if (seen !== want) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            want);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   function automatic logic [11:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[11:0];
   endfunction
   function automatic logic [15:0] cmd(input logic s, input logic nw,
                                       input logic [11:0] d);
      return {ADDR_IRQ_EN, s, nw, d};
   endfunction
   // the note is pushed before the frame; image is the expected payload
   task automatic spi(input logic [15:0] w, input int n, input logic c,
                      input logic [11:0] img);
      exp_q.push_back({c, ADDR_IRQ_EN, 2'b00, img});
      host.frame(w, n);
   endtask
   // flip event inputs for four clocks, then let the edges settle
   task automatic pulse(input logic [18:0] m);
      @(negedge mclk);
      ins = ins ^ m;
      repeat (4) @(negedge mclk);
      ins = ins ^ m;
      repeat (6) @(negedge mclk);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      logic [11:0] v;
      int          r0;
      nrst = 1'b0;
      mode = MODE_NORMAL;
      ins = 19'h43c00;
      wake_global_en = 1'b1;
      transceiver_supply_on = 1'b1;
      repeat (8) @(negedge mclk);
      check(en_w, {4'h0, EN_RESET});
      check(irq_w, 16'h0001);
      nrst = 1'b1;
      repeat (4) @(negedge mclk);
      // random images, each followed by a read-only frame
      for (int k = 0; k < 4; k++) begin
         v = rnd();
         spi(cmd(1'b0, 1'b0, v), 16, 1'b0, 12'h000);
         check(en_w, {4'h0, v});
         spi(cmd(1'b0, 1'b1, ~v), 16, 1'b1, v);
         check(en_w, {4'h0, v});
      end
      $display("test enable write and readback done");
      spi(cmd(1'b1, 1'b0, 12'hfff), 16, 1'b0, 12'h000);
      for (int t = 0; t < 11; t++) begin
         pulse(ev_m[t]);
         check(irq_w, 16'h0000);
         spi(cmd(1'b1, 1'b1, 12'h000), 16, 1'b1, 12'h001 << ev_b[t]);
         check(irq_w, 16'h0001);
      end
      spi(cmd(1'b1, 1'b0, 12'h000), 16, 1'b0, 12'h000);
      r0 = resets;
      for (int t = 0; t < 11; t++) begin
         pulse(ev_m[t]);
         check(irq_w, 16'h0001);
      end
      check(16'(resets), 16'(r0));
      spi(cmd(1'b1, 1'b0, 12'hfff), 16, 1'b0, 12'h000);
      @(negedge mclk);
      wake_global_en = 1'b0;
      pulse(19'h40000);
      check(irq_w, 16'h0001);
      wake_global_en = 1'b1;
      $display("test event enables done");
      mode = MODE_STANDBY;
      spi(cmd(1'b1, 1'b0, 12'h000), 16, 1'b0, 12'h000);
      for (int t = 0; t < 4; t++) begin
         r0 = resets;
         pulse(rs_m[t]);
         check(16'(resets), 16'(r0 + 1));
      end
      spi(cmd(1'b1, 1'b0, 12'hfff), 16, 1'b0, 12'h000);
      r0 = resets;
      pulse(19'h20000);
      check(irq_w, 16'h0000);
      check(en_w, 16'h07ff);
      check(16'(resets), 16'(r0));
      spi(cmd(1'b1, 1'b1, 12'h000), 16, 1'b1, 12'h800);
      $display("test standby wake and overflow done");
      @(negedge mclk);
      mode = MODE_NORMAL;
      spi(cmd(1'b1, 1'b0, 12'h100), 16, 1'b0, 12'h000);
      spi(cmd(1'b0, 1'b0, 12'h0ff), 15, 1'b0, 12'h000);
      check(en_w, 16'h0100);
      check(irq_w, 16'h0000);
      spi(cmd(1'b0, 1'b0, 12'h0ff), 17, 1'b0, 12'h000);
      check(en_w, 16'h0100);
      spi(cmd(1'b1, 1'b1, 12'h000), 16, 1'b1, 12'h100);
      check(irq_w, 16'h0001);
      for (int k = 0; k < 2; k++) begin
         @(negedge mclk);
         mode = (k == 0) ? MODE_STARTUP : MODE_RESTART;
         r0 = resets;
         spi(cmd(1'b0, 1'b0, 12'h0ff), 15, 1'b0, 12'h000);
         check(16'(resets), 16'(r0 + 1));
      end
      $display("test clock count faults done");
      @(negedge mclk);
      mode = MODE_NORMAL;
      transceiver_supply_on = 1'b0;
      ins = ins ^ 19'h00800;
      repeat (6) @(negedge mclk);
      check({14'h0000, code}, {14'h0000, XCVR_OFFLINE});
      check({15'h0000, sup_ok}, 16'h0000);
      ins = ins ^ 19'h00802;
      transceiver_supply_on = 1'b1;
      repeat (6) @(negedge mclk);
      check({14'h0000, code}, {14'h0000, XCVR_ACTIVE});
      check({15'h0000, sup_ok}, 16'h0001);
      ins = ins ^ 19'h00002;
      repeat (3) @(negedge mclk);
      check({14'h0000, code}, {14'h0000, XCVR_ONLINE});
      $display("test transceiver state done");
      // a reset in mid-run drops a pending cause and the enables
      spi(cmd(1'b0, 1'b0, 12'h000), 15, 1'b0, 12'h000);
      check(irq_w, 16'h0000);
      @(negedge mclk);
      nrst = 1'b0;
      @(negedge mclk);
      check(irq_w, 16'h0001);
      check(en_w, {4'h0, EN_RESET});
      nrst = 1'b1;
      repeat (4) @(negedge mclk);
      spi(cmd(1'b1, 1'b1, 12'h000), 16, 1'b1, 12'h000);
      $display("test reset in mid-run done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
